// ### hw/sfp_fifo.sv
// Operation
// - Registers on input and output data paths
// - Accesses only act at clock edges
// - Write and read sides share one clock
// - Flags change only at clock edges
// - Level flags follow either side's activity
// - Separate pointers; flags from their comparison
// - Empty when read pointer meets write pointer
// - Full when last location gets written
// - Half flag at level of half depth
// - Almost-empty clears after n stored words
// - Almost-full at depth minus full offset
// - Thresholds held in programmable offset registers
// - Load select and enable decode write edge
// - Depth is select (zero as one) times base depth, clipped to the array
// - Loads go empty, full, then depth select
// - Read data appears one clock later
// - First write stores without extra latency
//
// The AHB-Lite register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none

module sfp_fifo #(
    parameter int unsigned DATA_W = sfp_pkg::DATA_W_DEF,
    parameter int unsigned ADDR_W = sfp_pkg::ADDR_W_DEF,
    parameter int unsigned BASE_DEPTH = sfp_pkg::BASE_DEPTH_DEF,
    parameter int unsigned SEL_W = sfp_pkg::SEL_W_DEF
) (
    input wire logic I_MCLK,
    input wire logic I_ARST_N,
    input wire logic I_HSEL,
    input wire logic [31:0] I_HADDR,
    input wire logic [1:0] I_HTRANS,
    input wire logic I_HWRITE,
    input wire logic [2:0] I_HSIZE,
    input wire logic [31:0] I_HWDATA,
    input wire logic I_HREADY,
    output logic [31:0] O_HRDATA,
    output logic O_HREADYOUT,
    output logic O_HRESP,
    input wire logic I_WR_EN_N,
    input wire logic I_LOAD_SEL_N,
    input wire logic [DATA_W-1:0] I_WR_DATA,
    input wire logic I_RD_EN_N,
    output logic [DATA_W-1:0] O_RD_DATA,
    output logic O_EMPTY,
    output logic O_FULL,
    output logic O_HALF,
    output logic O_ALMOST_EMPTY,
    output logic O_ALMOST_FULL,
    output logic O_IRQ
);

    localparam int unsigned CW = ADDR_W + 1;
    localparam int unsigned RAM_DEPTH = 1 << ADDR_W;
    localparam int unsigned EVW = sfp_pkg::EV_W;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [ADDR_W-1:0] wptr;
        logic wlap;
        logic [ADDR_W-1:0] rptr;
        logic rlap;
        logic [DATA_W-1:0] in_data;
        logic [DATA_W-1:0] out_data;
        logic [CW-1:0] empty_off;
        logic [CW-1:0] full_off;
        logic [SEL_W-1:0] depth_sel;
        sfp_pkg::sfp_load_t load_step;
        logic empty;
        logic full;
        logic half;
        logic aempty;
        logic afull;
        logic [EVW-1:0] status;
        logic [EVW-1:0] mask;
        logic irq;
        logic dp_act;
        logic dp_wr;
        logic [7:0] dp_addr;
        logic [31:0] hrdata;
        logic hreadyout;
        logic hresp;
    } sfp_state_t;

    localparam sfp_state_t ST_RST = '{
        empty_off: CW'(sfp_pkg::EMPTY_OFF_RST),
        full_off: CW'(sfp_pkg::FULL_OFF_RST),
        depth_sel: SEL_W'(sfp_pkg::DEPTH_SEL_RST),
        mask: EVW'(sfp_pkg::MASK_RST),
        load_step: sfp_pkg::SFP_LD_EMPTY,
        empty: 1'b1,
        aempty: 1'b1,
        hreadyout: 1'b1,
        default: '0
    };

    sfp_state_t st_reg;
    sfp_state_t st_next;
    logic ram_we;
    logic [DATA_W-1:0] ram_q;

    // ------------------------------------------------------------------
    // Fill level from the two pointers and their lap bits
    // ------------------------------------------------------------------
    function automatic logic [CW-1:0] level_of(
        input logic [ADDR_W-1:0] w,
        input logic wl,
        input logic [ADDR_W-1:0] r,
        input logic rl,
        input logic [CW-1:0] d
    );
        logic [CW-1:0] diff;
        diff = {1'b0, w} - {1'b0, r};
        // Differing laps mean the writer is one turn ahead
        if (wl != rl) begin
            diff = diff + d;
        end
        return diff;
    endfunction : level_of

    // ------------------------------------------------------------------
    // Storage array
    // ------------------------------------------------------------------
    sfp_ram #(
        .DATA_W(DATA_W),
        .ADDR_W(ADDR_W)
    ) u_ram (
        .i_clk(I_MCLK),
        .i_arst_n(I_ARST_N),
        .i_we(ram_we),
        .i_waddr(st_reg.wptr),
        .i_wdata(I_WR_DATA),
        .i_raddr(st_reg.rptr),
        .o_rdata(ram_q)
    );

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        logic load_go;
        logic wr_go;
        logic rd_go;
        logic flush;
        logic [31:0] depth_prod;
        logic [CW-1:0] cfg_depth;
        logic [CW-1:0] lvl;
        logic [CW:0] afull_sum;
        logic [EVW-1:0] ev;
        logic [EVW-1:0] w1c;
        logic ap_go;
        load_go = 1'b0;
        wr_go = 1'b0;
        rd_go = 1'b0;
        flush = 1'b0;
        depth_prod = '0;
        cfg_depth = '0;
        lvl = '0;
        afull_sum = '0;
        ev = '0;
        w1c = '0;
        ap_go = 1'b0;
        st_next = st_reg;

        // Zero selects one base depth, as does one
        depth_prod = (st_reg.depth_sel == '0) ? 32'h1 : 32'(st_reg.depth_sel);
        depth_prod = depth_prod * BASE_DEPTH;
        // Larger selections are clipped to the physical array
        if (depth_prod > RAM_DEPTH) begin
            depth_prod = RAM_DEPTH;
        end
        cfg_depth = depth_prod[CW-1:0];

        // Enables are levels sampled at the edge; no strobes are shaped
        load_go = !I_WR_EN_N && !I_LOAD_SEL_N;
        wr_go = !I_WR_EN_N && I_LOAD_SEL_N;
        rd_go = !I_RD_EN_N;
        // Writes into a full array and reads of an empty one are dropped
        ram_we = wr_go && !st_reg.full;

        // --------------------------------------------------------------
        // Offset and depth programming through the write port
        // --------------------------------------------------------------
        if (load_go) begin
            case (st_reg.load_step)
                sfp_pkg::SFP_LD_EMPTY: begin
                    st_next.empty_off = I_WR_DATA[CW-1:0];
                    st_next.load_step = sfp_pkg::SFP_LD_FULL;
                end
                sfp_pkg::SFP_LD_FULL: begin
                    st_next.full_off = I_WR_DATA[CW-1:0];
                    st_next.load_step = sfp_pkg::SFP_LD_DEPTH;
                end
                sfp_pkg::SFP_LD_DEPTH: begin
                    st_next.depth_sel = I_WR_DATA[SEL_W-1:0];
                    st_next.load_step = sfp_pkg::SFP_LD_EMPTY;
                end
                default: begin
                    st_next.load_step = sfp_pkg::SFP_LD_EMPTY;
                end
            endcase
        end else if (wr_go) begin
            st_next.load_step = sfp_pkg::SFP_LD_EMPTY;
        end

        // --------------------------------------------------------------
        // Write side: input register and array share the same edge
        // --------------------------------------------------------------
        if (ram_we) begin
            st_next.in_data = I_WR_DATA;
            if ({1'b0, st_reg.wptr} >= cfg_depth - CW'(1)) begin
                st_next.wptr = '0;
                st_next.wlap = !st_reg.wlap;
            end else begin
                st_next.wptr = st_reg.wptr + ADDR_W'(1);
            end
        end

        // --------------------------------------------------------------
        // Read side: the output register adds one clock of latency
        // --------------------------------------------------------------
        if (rd_go && !st_reg.empty) begin
            st_next.out_data = ram_q;
            if ({1'b0, st_reg.rptr} >= cfg_depth - CW'(1)) begin
                st_next.rptr = '0;
                st_next.rlap = !st_reg.rlap;
            end else begin
                st_next.rptr = st_reg.rptr + ADDR_W'(1);
            end
        end

        // --------------------------------------------------------------
        // Register bus write, data phase
        // --------------------------------------------------------------
        if (st_reg.dp_act && st_reg.dp_wr) begin
            case (st_reg.dp_addr)
                sfp_pkg::OFS_STATUS: begin
                    w1c = I_HWDATA[EVW-1:0];
                end
                sfp_pkg::OFS_MASK: begin
                    st_next.mask = I_HWDATA[EVW-1:0];
                end
                sfp_pkg::OFS_EMPTY_OFF: begin
                    st_next.empty_off = I_HWDATA[CW-1:0];
                end
                sfp_pkg::OFS_FULL_OFF: begin
                    st_next.full_off = I_HWDATA[CW-1:0];
                end
                sfp_pkg::OFS_DEPTH_SEL: begin
                    st_next.depth_sel = I_HWDATA[SEL_W-1:0];
                end
                sfp_pkg::OFS_CTRL: begin
                    flush = I_HWDATA[sfp_pkg::CTRL_FLUSH];
                end
                default: begin
                end
            endcase
        end

        // Flush drops stored words; it wins over a same-cycle transfer
        if (flush) begin
            st_next.wptr = '0;
            st_next.wlap = 1'b0;
            st_next.rptr = '0;
            st_next.rlap = 1'b0;
        end

        // --------------------------------------------------------------
        // Flags from the pointer comparison, registered at the edge
        // --------------------------------------------------------------
        lvl = level_of(st_next.wptr, st_next.wlap, st_next.rptr, st_next.rlap,
            cfg_depth);
        st_next.empty = (lvl == '0);
        st_next.full = (lvl >= cfg_depth);
        // Either side's transfer moves these three, whichever came last
        st_next.half = (lvl >= (cfg_depth >> 1));
        st_next.aempty = (lvl < st_next.empty_off);
        afull_sum = {1'b0, lvl} + {1'b0, st_next.full_off};
        st_next.afull = (afull_sum >= {1'b0, cfg_depth});

        // --------------------------------------------------------------
        // Sticky events; a new event beats a same-cycle clear
        // --------------------------------------------------------------
        ev[sfp_pkg::EV_EMPTY] = st_next.empty && !st_reg.empty;
        ev[sfp_pkg::EV_FULL] = st_next.full && !st_reg.full;
        ev[sfp_pkg::EV_HALF] = st_next.half && !st_reg.half;
        ev[sfp_pkg::EV_AEMPTY] = st_next.aempty && !st_reg.aempty;
        ev[sfp_pkg::EV_AFULL] = st_next.afull && !st_reg.afull;
        ev[sfp_pkg::EV_OVERFLOW] = wr_go && st_reg.full;
        ev[sfp_pkg::EV_UNDERFLOW] = rd_go && st_reg.empty;
        st_next.status = (st_reg.status & ~w1c) | ev;
        st_next.irq = |(st_next.status & st_next.mask);

        // --------------------------------------------------------------
        // Register bus address phase; zero wait states, always OKAY
        // --------------------------------------------------------------
        ap_go = I_HSEL && I_HTRANS[1] && I_HREADY;
        st_next.dp_act = ap_go;
        st_next.dp_wr = I_HWRITE;
        st_next.dp_addr = I_HADDR[7:0];
        st_next.hreadyout = 1'b1;
        st_next.hresp = 1'b0;
        st_next.hrdata = '0;
        // Read data is taken from next state so a write just before shows
        if (ap_go && !I_HWRITE) begin
            case (I_HADDR[7:0])
                sfp_pkg::OFS_STATUS: begin
                    st_next.hrdata[EVW-1:0] = st_next.status;
                end
                sfp_pkg::OFS_MASK: begin
                    st_next.hrdata[EVW-1:0] = st_next.mask;
                end
                sfp_pkg::OFS_FLAGS: begin
                    st_next.hrdata[sfp_pkg::EV_EMPTY] = st_next.empty;
                    st_next.hrdata[sfp_pkg::EV_FULL] = st_next.full;
                    st_next.hrdata[sfp_pkg::EV_HALF] = st_next.half;
                    st_next.hrdata[sfp_pkg::EV_AEMPTY] = st_next.aempty;
                    st_next.hrdata[sfp_pkg::EV_AFULL] = st_next.afull;
                end
                sfp_pkg::OFS_LEVEL: begin
                    st_next.hrdata[CW-1:0] = lvl;
                end
                sfp_pkg::OFS_EMPTY_OFF: begin
                    st_next.hrdata[CW-1:0] = st_next.empty_off;
                end
                sfp_pkg::OFS_FULL_OFF: begin
                    st_next.hrdata[CW-1:0] = st_next.full_off;
                end
                sfp_pkg::OFS_DEPTH_SEL: begin
                    st_next.hrdata[SEL_W-1:0] = st_next.depth_sel;
                end
                sfp_pkg::OFS_LAST_IN: begin
                    st_next.hrdata[DATA_W-1:0] = st_next.in_data;
                end
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Single register stage; both sides run on the one clock
    // ------------------------------------------------------------------
    always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            st_reg <= ST_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign O_HRDATA = st_reg.hrdata;
    assign O_HREADYOUT = st_reg.hreadyout;
    assign O_HRESP = st_reg.hresp;
    assign O_RD_DATA = st_reg.out_data;
    assign O_EMPTY = st_reg.empty;
    assign O_FULL = st_reg.full;
    assign O_HALF = st_reg.half;
    assign O_ALMOST_EMPTY = st_reg.aempty;
    assign O_ALMOST_FULL = st_reg.afull;
    assign O_IRQ = st_reg.irq;

endmodule : sfp_fifo

`default_nettype wire

// ### hw/sfp_pkg.sv
`default_nettype none

package sfp_pkg;

    // ------------------------------------------------------------------
    // Storage geometry defaults
    // ------------------------------------------------------------------
    localparam int unsigned BASE_DEPTH_DEF = 512;
    localparam int unsigned ADDR_W_DEF = 10;
    localparam int unsigned DATA_W_DEF = 18;
    localparam int unsigned SEL_W_DEF = 8;

    // ------------------------------------------------------------------
    // Reset values of the programmable registers
    // ------------------------------------------------------------------
    localparam int unsigned EMPTY_OFF_RST = 7;
    localparam int unsigned FULL_OFF_RST = 7;
    localparam int unsigned DEPTH_SEL_RST = 0;
    localparam int unsigned MASK_RST = 0;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_STATUS = 8'h00;
    localparam logic [7:0] OFS_MASK = 8'h04;
    localparam logic [7:0] OFS_FLAGS = 8'h08;
    localparam logic [7:0] OFS_LEVEL = 8'h0c;
    localparam logic [7:0] OFS_EMPTY_OFF = 8'h10;
    localparam logic [7:0] OFS_FULL_OFF = 8'h14;
    localparam logic [7:0] OFS_DEPTH_SEL = 8'h18;
    localparam logic [7:0] OFS_LAST_IN = 8'h1c;
    localparam logic [7:0] OFS_CTRL = 8'h20;

    // ------------------------------------------------------------------
    // Event and flag bit positions (status, mask and flags share them)
    // ------------------------------------------------------------------
    localparam int unsigned EV_W = 7;
    localparam int unsigned EV_EMPTY = 0;
    localparam int unsigned EV_FULL = 1;
    localparam int unsigned EV_HALF = 2;
    localparam int unsigned EV_AEMPTY = 3;
    localparam int unsigned EV_AFULL = 4;
    localparam int unsigned EV_OVERFLOW = 5;
    localparam int unsigned EV_UNDERFLOW = 6;
    localparam int unsigned CTRL_FLUSH = 0;

    // ------------------------------------------------------------------
    // Programming sequence of the write port
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        SFP_LD_EMPTY = 2'b00,
        SFP_LD_FULL = 2'b01,
        SFP_LD_DEPTH = 2'b10
    } sfp_load_t;

endpackage : sfp_pkg

`default_nettype wire

// ### hw/sfp_ram.sv
`timescale 1ns/1ps
`default_nettype none

module sfp_ram #(
    parameter int unsigned DATA_W = sfp_pkg::DATA_W_DEF,
    parameter int unsigned ADDR_W = sfp_pkg::ADDR_W_DEF
) (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_we,
    input wire logic [ADDR_W-1:0] i_waddr,
    input wire logic [DATA_W-1:0] i_wdata,
    input wire logic [ADDR_W-1:0] i_raddr,
    output logic [DATA_W-1:0] o_rdata
);

    localparam int unsigned DEPTH = 1 << ADDR_W;

    typedef struct packed {
        logic [DEPTH-1:0][DATA_W-1:0] mem;
    } sfp_ram_state_t;

    sfp_ram_state_t ram_reg;
    sfp_ram_state_t ram_next;

    // ------------------------------------------------------------------
    // Two ports: write on the clock edge, read is asynchronous
    // ------------------------------------------------------------------
    always_comb begin
        ram_next = ram_reg;
        for (int i = 0; i < DEPTH; i++) begin
            if (i_we && (i_waddr == ADDR_W'(i))) begin
                ram_next.mem[i] = i_wdata;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ram_reg <= '0;
        end else begin
            ram_reg <= ram_next;
        end
    end

    assign o_rdata = ram_reg.mem[i_raddr];

endmodule : sfp_ram

`default_nettype wire

// ### test/sfp_fifo_monitor.sv
`timescale 1ns/1ps
`default_nettype none

module sfp_fifo_monitor #(
    parameter int unsigned DATA_W = 18
) (
    input wire logic I_MCLK,
    input wire logic I_ARST_N,
    input wire logic [1:0] I_HTRANS,
    input wire logic I_WR_EN_N,
    input wire logic I_LOAD_SEL_N,
    input wire logic I_RD_EN_N,
    input wire logic [DATA_W-1:0] O_RD_DATA,
    input wire logic O_EMPTY,
    input wire logic O_FULL,
    input wire logic O_HALF,
    input wire logic O_ALMOST_EMPTY,
    input wire logic O_ALMOST_FULL
);
    default clocking cb @(posedge I_MCLK);
    endclocking
    default disable iff (!I_ARST_N);

    // ----------------
    // Sequences
    // ----------------
    // Bus writes (flush, offsets) may legally move flags, so quiet cycles exclude them
    sequence s_quiet;
        I_LOAD_SEL_N && !I_HTRANS[1] && !$past(I_HTRANS[1]);
    endsequence
    sequence s_lone_write;
        O_EMPTY && !I_WR_EN_N && I_RD_EN_N ##0 s_quiet;
    endsequence
    sequence s_lone_read;
        I_WR_EN_N && !I_RD_EN_N ##0 s_quiet;
    endsequence

    a_write_fills: assert property (s_lone_write |=> !O_EMPTY)
        else $error("write into empty fifo left it empty");
    a_last_read_empties: assert property (s_lone_write ##1 s_lone_read |=> O_EMPTY)
        else $error("reading the only word did not set empty");
    a_empty_stays: assert property (O_EMPTY && I_WR_EN_N ##0 s_quiet |=> O_EMPTY)
        else $error("empty dropped without a write");
    a_full_refuses: assert property (O_FULL && I_RD_EN_N ##0 s_quiet |=> O_FULL)
        else $error("full dropped without a read");
    a_full_drains: assert property (O_FULL ##0 s_lone_read |=> !O_FULL)
        else $error("read from full fifo kept full set");
    a_idle_flags_hold: assert property (I_WR_EN_N && I_RD_EN_N ##0 s_quiet
        |=> $stable({O_EMPTY, O_FULL, O_HALF, O_ALMOST_EMPTY, O_ALMOST_FULL}))
        else $error("flag moved in an idle cycle");
    a_read_data_hold: assert property ((I_RD_EN_N || O_EMPTY) ##0 s_quiet
        |=> $stable(O_RD_DATA))
        else $error("read data changed without an accepted read");
    a_empty_excl: assert property (O_EMPTY |-> !O_FULL && !O_HALF)
        else $error("empty together with full or half");
    a_full_implies: assert property (O_FULL |-> O_HALF && O_ALMOST_FULL)
        else $error("full without half or almost full");
endmodule : sfp_fifo_monitor

bind sfp_fifo sfp_fifo_monitor #(.DATA_W(DATA_W)) u_mon (
    .I_MCLK(I_MCLK), .I_ARST_N(I_ARST_N), .I_HTRANS(I_HTRANS), .I_WR_EN_N(I_WR_EN_N),
    .I_LOAD_SEL_N(I_LOAD_SEL_N), .I_RD_EN_N(I_RD_EN_N), .O_RD_DATA(O_RD_DATA),
    .O_EMPTY(O_EMPTY), .O_FULL(O_FULL), .O_HALF(O_HALF),
    .O_ALMOST_EMPTY(O_ALMOST_EMPTY), .O_ALMOST_FULL(O_ALMOST_FULL)
);

`default_nettype wire

// ### test/sfp_peer.sv
`timescale 1ns/1ps
`default_nettype none

module sfp_peer #(
    parameter int unsigned DATA_W = 18
) (
    input wire logic i_clk,
    output logic o_wr_en_n,
    output logic o_load_sel_n,
    output logic [DATA_W-1:0] o_wr_data,
    output logic o_rd_en_n
);
    initial begin
        o_wr_en_n = 1'b1;
        o_load_sel_n = 1'b1;
        o_wr_data = '0;
        o_rd_en_n = 1'b1;
    end

    // ----------------
    // Transfers
    // ----------------
    // Enables are plain levels held across one edge; no shaped strobes
    task automatic step(input bit wr, input bit ld, input bit rd, input logic [DATA_W-1:0] d);
        o_wr_en_n <= !wr;
        o_load_sel_n <= ld;
        o_wr_data <= d;
        o_rd_en_n <= !rd;
        @(posedge i_clk);
        o_wr_en_n <= 1'b1;
        o_load_sel_n <= 1'b1;
        o_rd_en_n <= 1'b1;
        // Released data lines show the inverse, never a stale valid word
        o_wr_data <= ~d;
    endtask : step

    // Short low pulse between edges, as a noisy line would make it
    task automatic glitch();
        o_wr_en_n <= #3 1'b0;
        o_wr_en_n <= #5 1'b1;
        @(posedge i_clk);
    endtask : glitch
endmodule : sfp_peer

`default_nettype wire

// ### test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    localparam int DW = 18;
    localparam int AW = 4;
    localparam int BD = 8;
    logic clk, arst_n, hsel, hwrite, hready, hresp, irq;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, r, fx;
    logic wr_en_n, ld_n, rd_en_n, f_empty, f_full, f_half, f_ae, f_af;
    logic [DW-1:0] wr_data, rd_data;
    int err_count = 0;
    int cmp_count = 0;
    int seed = 32'h4098;
    int cyc = 0;
    int depth = BD;
    int n = sfp_pkg::EMPTY_OFF_RST;
    int m = sfp_pkg::FULL_OFF_RST;
    int q[$];

    sfp_fifo #(.DATA_W(DW), .ADDR_W(AW), .BASE_DEPTH(BD), .SEL_W(8)) u_dut (
        .I_MCLK(clk), .I_ARST_N(arst_n), .I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans),
        .I_HWRITE(hwrite), .I_HSIZE(hsize), .I_HWDATA(hwdata), .I_HREADY(hready),
        .O_HRDATA(hrdata), .O_HREADYOUT(hready), .O_HRESP(hresp), .I_WR_EN_N(wr_en_n),
        .I_LOAD_SEL_N(ld_n), .I_WR_DATA(wr_data), .I_RD_EN_N(rd_en_n), .O_RD_DATA(rd_data),
        .O_EMPTY(f_empty), .O_FULL(f_full), .O_HALF(f_half), .O_ALMOST_EMPTY(f_ae),
        .O_ALMOST_FULL(f_af), .O_IRQ(irq)
    );

    sfp_peer #(.DATA_W(DW)) u_peer (
        .i_clk(clk), .o_wr_en_n(wr_en_n), .o_load_sel_n(ld_n), .o_wr_data(wr_data),
        .o_rd_en_n(rd_en_n)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ----------------
    // Checking helpers
    // ----------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : summarize

    // Watchdog: the whole run needs well under a thousand cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            err_count++;
            summarize();
        end
    end

    task automatic flags();
        int l;
        l = q.size();
        check(f_empty, l == 0);
        check(f_full, l == depth);
        check(f_half, l >= depth / 2);
        check(f_ae, l < n);
        check(f_af, l + m >= depth);
    endtask : flags

    task automatic bus(input bit wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h0, a};
        hwrite <= wr;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        rd = hrdata;
        check(hresp, 1'b0);
    endtask : bus

    // One edge of the data port; the model decides acceptance from its own level
    task automatic op(input bit wr, input bit rd);
        logic [DW-1:0] d;
        bit okw;
        bit okr;
        d = DW'($random(seed));
        okw = wr && q.size() < depth;
        okr = rd && q.size() > 0;
        u_peer.step(wr, 1'b1, rd, d);
        #1;
        if (okr) check(rd_data, q.pop_front());
        if (okw) q.push_back(d);
        flags();
    endtask : op

    task automatic cfg(input int sel, input int nn, input int mm);
        // Step off the edge so the release and the next drive never share a time step
        u_peer.step(1'b1, 1'b0, 1'b0, DW'(nn));
        #1 u_peer.step(1'b1, 1'b0, 1'b0, DW'(mm));
        #1 u_peer.step(1'b1, 1'b0, 1'b0, DW'(sel));
        n = nn;
        m = mm;
        depth = (sel < 2 ? 1 : sel) * BD;
        if (depth > 2 ** AW) depth = 2 ** AW;
        #1 flags();
        bus(1'b0, sfp_pkg::OFS_EMPTY_OFF, 32'h0, r);
        check(r, nn);
        bus(1'b0, sfp_pkg::OFS_FULL_OFF, 32'h0, r);
        check(r, mm);
        bus(1'b0, sfp_pkg::OFS_DEPTH_SEL, 32'h0, r);
        check(r, sel);
    endtask : cfg

    // ----------------
    // Main sequence
    // ----------------
    initial begin
        arst_n = 1'b0;
        hsel = 1'b0;
        haddr = '0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = '0;
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        #1 flags();
        check(irq, 1'b0);
        bus(1'b1, 8'hfc, 32'hffff, r);
        bus(1'b0, 8'hfc, 32'h0, r);
        check(r, 32'h0);
        u_peer.glitch();
        #1 flags();
        for (int s = 0; s < 3; s++) begin
            cfg(s, 1 + 5 * s, 2 + s);
            while (q.size() < depth) op(1'b1, 1'b0);
            check(f_full, 1'b1);
            bus(1'b0, sfp_pkg::OFS_LEVEL, 32'h0, r);
            check(r, q.size());
            bus(1'b1, sfp_pkg::OFS_STATUS, 32'h7f, r);
            op(1'b1, 1'b0);
            bus(1'b0, sfp_pkg::OFS_STATUS, 32'h0, r);
            check(r, 32'h20);
            while (q.size() > 0) op(1'b0, 1'b1);
        end
        bus(1'b1, sfp_pkg::OFS_STATUS, 32'h7f, r);
        bus(1'b1, sfp_pkg::OFS_MASK, 32'h40, r);
        op(1'b0, 1'b1);
        check(irq, 1'b1);
        bus(1'b1, sfp_pkg::OFS_STATUS, 32'h40, r);
        #1 check(irq, 1'b0);
        bus(1'b1, sfp_pkg::OFS_MASK, 32'h0, r);
        op(1'b0, 1'b1);
        check(irq, 1'b0);
        bus(1'b0, sfp_pkg::OFS_STATUS, 32'h0, r);
        check(r, 32'h40);
        op(1'b1, 1'b0);
        op(1'b0, 1'b1);
        repeat (150) op(($random(seed) & 3) != 0, ($random(seed) & 1) != 0);
        repeat (150) op(($random(seed) & 1) != 0, ($random(seed) & 3) != 0);
        // Leave at least one word stored so the input register and live flags are visible
        op(1'b1, 1'b0);
        bus(1'b1, sfp_pkg::OFS_EMPTY_OFF, 32'h3, r);
        n = 3;
        bus(1'b0, sfp_pkg::OFS_LAST_IN, 32'h0, r);
        check(r, q[$]);
        fx = {q.size() + m >= depth, q.size() < n, q.size() >= depth / 2,
              q.size() == depth, q.size() == 0};
        bus(1'b0, sfp_pkg::OFS_FLAGS, 32'h0, r);
        check(r, fx);
        bus(1'b1, sfp_pkg::OFS_CTRL, 32'h1, r);
        q.delete();
        #1 flags();
        bus(1'b0, sfp_pkg::OFS_LEVEL, 32'h0, r);
        check(r, 32'h0);
        summarize();
    end
endmodule : tb_top

`default_nettype wire
